// ### hw/smc_params.svh
// Constants of the supply monitor control block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from package and modules alike.
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// Register byte offsets
`define SMC_ADDR_CTRL   8'h00
`define SMC_ADDR_IOCFG  8'h04
`define SMC_ADDR_MON    8'h08
`define SMC_ADDR_STAT   8'h0c
`define SMC_ADDR_IRQEN  8'h10

// Control register fields
`define SMC_C_PASS      0
`define SMC_C_XCVR      1
`define SMC_C_AUX       2
`define SMC_C_AUX33     3
`define SMC_C_TH1RST    4
`define SMC_C_LOWSEL    5
`define SMC_C_LOAD      6
`define SMC_C_LPACT     8
`define SMC_CTRL_W      10

// I/O configuration fields
`define SMC_IO_LPON     8
`define SMC_IO_CYC      12
`define SMC_IOCFG_W     13

// Status bits
`define SMC_S_LOSS      0
`define SMC_S_OV        1
`define SMC_S_UV        2
`define SMC_S_AUX       3
`define SMC_S_XUV       4
`define SMC_S_RSTF      5
`define SMC_S_VWARN     6
`define SMC_S_BEW       7
`define SMC_S_LPOC      8
`define SMC_STAT_W      9

// Reset values
`define SMC_CTRL_RST    10'h000
`define SMC_IOCFG_RST   13'h0000
`define SMC_STAT_RST    9'h001
`define SMC_IRQEN_RST   9'h000

// Encodings
`define SMC_IO_IN       2'h0
`define SMC_IO_HS       2'h1
`define SMC_IO_LS       2'h2
`define SMC_LP_WAKE     2'h0
`define SMC_LP_TIMER    2'h1
`define SMC_LP_WDOG     2'h2
`define SMC_MON_OFF     3'h0
`define SMC_RESP_OK     2'h0
`define SMC_RESP_ERR    2'h2

// Timing
`define SMC_CLK_NS      10
`define SMC_RSTCHK_NS   1000
`define SMC_RSTCHK_CYC  ((`SMC_RSTCHK_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)

`endif

// ### hw/smc_pkg.sv
// Types of the supply monitor control block.
// Assumes smc_params.svh on the include path.
`include "smc_params.svh"
package smc_pkg;

	// Detector levels and pin readbacks, all asynchronous
	typedef struct packed {
		logic       bat_loss;
		logic       sup_ov;
		logic       sup_uv;
		logic       aux_uv;
		logic       aux_oc;
		logic       vdd_lt_upper;
		logic       vdd_lt_lower;
		logic       rst_pin_hi;
		logic       lp_ovc;
		logic       bat_low;
		logic       xcvr_uv;
		logic [3:0] io_in;
	} smc_pins_t;

	// Controls toward the analog section
	typedef struct packed {
		logic       por;
		logic       pass_en;
		logic       xcvr_en;
		logic       lin_en;
		logic       aux_en;
		logic       aux_3v3;
		logic       mon_load;
		logic       rst_out;
		logic       rst_oe;
		logic       int_req;
		logic       io_prot_en;
		logic       wake;
		logic       ovc_timer;
		logic       wd_refresh;
		logic [2:0] mon_sel;
		logic [3:0] io_hs;
		logic [3:0] io_ls;
	} smc_ctl_t;

	// Whole state of the top module
	typedef struct packed {
		logic                    aw_rdy;
		logic                    w_rdy;
		logic                    aw_got;
		logic                    w_got;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    ar_rdy;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [31:0]             rdata;
		logic [7:0]              awaddr;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic                    boot;
		logic [`SMC_CTRL_W-1:0]  ctrl;
		logic [`SMC_IOCFG_W-1:0] iocfg;
		logic [2:0]              mon;
		logic [`SMC_STAT_W-1:0]  stat;
		logic [`SMC_STAT_W-1:0]  irqen;
		logic [7:0]              chk_cnt;
		smc_pins_t               pins_p;
		smc_ctl_t                ctl;
	} smc_state_t;

endpackage

// ### hw/smc_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
module smc_sync3 #(
	parameter int W = 1
) (
	input  wire logic         core_clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} smc_sync_t;

	smc_sync_t st;
	smc_sync_t nx;

	// First stage feeds only the second stage
	always_comb begin
		nx    = st;
		nx.s1 = d_i;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				nx.q[i] = st.s3[i];
			end
		end
		if (!nrst_i) begin
			nx = '0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		st <= nx;
	end

	assign q_o = st.q;
endmodule // smc_sync3

// ### hw/smc_top.sv
// Supply monitor control: regulator enables, undervoltage reset, I/O modes,
// monitor select, fault flags, reached over an AXI4-Lite slave.
// Assumes detector levels arrive asynchronously; lp_mode_i and debug_i are
// on core_clk_i.
//
// Summary of operation
// - Battery loss sets flag, requests power-on reset
// - Supply over/undervoltage flagged, each can interrupt
// - Low-power overcurrent: wake, timer start or refresh
// - Software bit drives external pass transistor
// - Transceiver rail off at reset; on in debug
// - Monitor and LIN need transceiver rail on
// - Software selects auxiliary rail level
// - Auxiliary rail off at reset, software switches
// - Auxiliary fault disables rail, flags, may interrupt
// - Reset pin stuck against drive is flagged
// - Undervoltage reset also acts in low power
// - Software picks reset or interrupt, upper threshold
// - Lower selected: upper interrupts, lower resets
// - I/O pins: high, low, open, input default
// - Low power keeps I/O state, protection off
// - Cyclic sense: pin 0 output, 1-3 wake
// - Monitor source chosen from seven choices
// - Software connects monitor load resistor
// - Source select ignored while transceiver rail off
// - Transceiver rail undervoltage readable as status
// - Battery sense crossing raises early warning
`timescale 1ns/1ps
`include "smc_params.svh"
module smc_top (
	input  wire logic              core_clk_i,
	input  wire logic              nrst_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [7:0]        s_axi_awaddr_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	output logic [1:0]             s_axi_bresp_o,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	input  wire logic [7:0]        s_axi_araddr_i,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	input  wire logic              lp_mode_i,
	input  wire logic              debug_i,
	input  wire smc_pkg::smc_pins_t pins_i,
	output smc_pkg::smc_ctl_t      ctl_o
);
	import smc_pkg::*;

	smc_state_t st;
	smc_state_t nx;
	smc_pins_t  pins_s;
	logic       wr_do;
	logic       ovc_ev;
	logic       rst_miss;
	logic [3:1] io_edge;

	// Known register offset check, shared by read and write paths
	function automatic logic addr_ok(input logic [7:0] a);
		return a == `SMC_ADDR_CTRL || a == `SMC_ADDR_IOCFG || a == `SMC_ADDR_MON ||
			a == `SMC_ADDR_STAT || a == `SMC_ADDR_IRQEN;
	endfunction

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Pin drive from configured mode and on state
	function automatic logic [1:0] io_drv(input logic [1:0] mode, input logic on);
		logic [1:0] r;
		r = 2'h0;
		unique case (mode)
			`SMC_IO_HS: r = {on, 1'b0};
			`SMC_IO_LS: r = {1'b0, on};
			default:    r = 2'h0;
		endcase
		return r;
	endfunction

	// Every detector is asynchronous to this clock
	smc_sync3 #(
		.W($bits(smc_pins_t))
	) u_sync (
		.core_clk_i(core_clk_i),
		.nrst_i    (nrst_i),
		.d_i       (pins_i),
		.q_o       (pins_s)
	);

	// Write commits one cycle after both address and data are held
	assign wr_do = st.aw_got && st.w_got && !st.bvalid;
	// Overcurrent only counts while the core rail is kept on in low power
	assign ovc_ev = pins_s.lp_ovc && !st.pins_p.lp_ovc && lp_mode_i;
	// Drive and readback disagree: stuck high or stuck at ground
	assign rst_miss = st.ctl.rst_oe == pins_s.rst_pin_hi;
	assign io_edge = pins_s.io_in[3:1] ^ st.pins_p.io_in[3:1];

	// Single next-state process for bus, registers and controls
	always_comb begin
		logic [31:0]            w;
		logic [`SMC_STAT_W-1:0] set;
		logic [`SMC_STAT_W-1:0] clr;
		logic [1:0]             d;
		w   = '0;
		set = '0;
		clr = '0;
		d   = '0;
		nx  = st;
		nx.pins_p = pins_s;

		// Write address and data channels, taken in either order
		if (s_axi_awvalid_i && st.aw_rdy) begin
			nx.aw_got = 1'b1;
			nx.aw_rdy = 1'b0;
			nx.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && st.w_rdy) begin
			nx.w_got = 1'b1;
			nx.w_rdy = 1'b0;
			nx.wdata = s_axi_wdata_i;
			nx.wstrb = s_axi_wstrb_i;
		end
		if (st.bvalid && s_axi_bready_i) begin
			nx.bvalid = 1'b0;
			nx.aw_rdy = 1'b1;
			nx.w_rdy  = 1'b1;
		end

		// Register writes
		if (wr_do) begin
			nx.aw_got = 1'b0;
			nx.w_got  = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp  = addr_ok(st.awaddr) ? `SMC_RESP_OK : `SMC_RESP_ERR;
			unique case (st.awaddr)
				`SMC_ADDR_CTRL: begin
					w = merge({22'h0, st.ctrl}, st.wdata, st.wstrb);
					// Enable bits taken as written, aux only by this command
					nx.ctrl = w[`SMC_CTRL_W-1:0];
				end
				`SMC_ADDR_IOCFG: begin
					w = merge({19'h0, st.iocfg}, st.wdata, st.wstrb);
					nx.iocfg = w[`SMC_IOCFG_W-1:0];
				end
				`SMC_ADDR_MON: begin
					// Source select needs the buffer supply present
					if (st.ctl.xcvr_en && st.wstrb[0]) begin
						nx.mon = st.wdata[2:0];
					end
				end
				`SMC_ADDR_STAT: begin
					w = merge(32'h0, st.wdata, st.wstrb);
					clr = w[`SMC_STAT_W-1:0];
				end
				`SMC_ADDR_IRQEN: begin
					w = merge({23'h0, st.irqen}, st.wdata, st.wstrb);
					nx.irqen = w[`SMC_STAT_W-1:0];
				end
				default: nx.bresp = `SMC_RESP_ERR;
			endcase
		end

		// Read channel, answer one cycle after the address is taken
		if (st.rvalid && s_axi_rready_i) begin
			nx.rvalid = 1'b0;
			nx.ar_rdy = 1'b1;
		end
		if (s_axi_arvalid_i && st.ar_rdy) begin
			nx.ar_rdy = 1'b0;
			nx.rvalid = 1'b1;
			nx.rresp  = addr_ok(s_axi_araddr_i) ? `SMC_RESP_OK : `SMC_RESP_ERR;
			unique case (s_axi_araddr_i)
				`SMC_ADDR_CTRL:  nx.rdata = {22'h0, st.ctrl};
				`SMC_ADDR_IOCFG: nx.rdata = {19'h0, st.iocfg};
				`SMC_ADDR_MON:   nx.rdata = {29'h0, st.mon};
				`SMC_ADDR_STAT:  nx.rdata = {23'h0, st.stat};
				`SMC_ADDR_IRQEN: nx.rdata = {23'h0, st.irqen};
				default:         nx.rdata = 32'h0;
			endcase
		end

		// Debug strap read once, first cycle after reset release
		if (st.boot) begin
			nx.boot = 1'b0;
			nx.ctrl[`SMC_C_XCVR] = debug_i;
		end

		// Auxiliary fault trips only a running rail; a same-cycle enable of a stopped rail still takes effect
		if ((pins_s.aux_uv || pins_s.aux_oc) && st.ctrl[`SMC_C_AUX]) begin
			nx.ctrl[`SMC_C_AUX] = 1'b0;
			set[`SMC_S_AUX] = 1'b1;
		end

		// Reset pin readback filter, must disagree for the whole window
		if (rst_miss) begin
			if (st.chk_cnt < 8'(`SMC_RSTCHK_CYC)) begin
				nx.chk_cnt = st.chk_cnt + 8'h01;
			end else begin
				set[`SMC_S_RSTF] = 1'b1;
			end
		end else begin
			nx.chk_cnt = 8'h00;
		end

		// Sticky event flags; a set in the clearing cycle survives
		set[`SMC_S_LOSS] = pins_s.bat_loss;
		set[`SMC_S_OV] = pins_s.sup_ov;
		set[`SMC_S_UV] = pins_s.sup_uv;
		set[`SMC_S_XUV] = pins_s.xcvr_uv;
		set[`SMC_S_BEW] = pins_s.bat_low;
		set[`SMC_S_LPOC] = ovc_ev;
		set[`SMC_S_VWARN] = pins_s.vdd_lt_upper &&
			(st.ctrl[`SMC_C_LOWSEL] || !st.ctrl[`SMC_C_TH1RST]);
		nx.stat = (st.stat & ~clr) | set;

		// Control outputs, all registered
		nx.ctl.por = pins_s.bat_loss;
		nx.ctl.pass_en = st.ctrl[`SMC_C_PASS];
		nx.ctl.xcvr_en = st.ctrl[`SMC_C_XCVR];
		nx.ctl.lin_en = st.ctrl[`SMC_C_XCVR];
		nx.ctl.aux_en = nx.ctrl[`SMC_C_AUX];
		nx.ctl.aux_3v3 = st.ctrl[`SMC_C_AUX33];
		nx.ctl.mon_load = st.ctrl[`SMC_C_LOAD];
		// Output forced to off code keeps the pin near ground
		nx.ctl.mon_sel = st.ctrl[`SMC_C_XCVR] ? st.mon : `SMC_MON_OFF;
		nx.ctl.int_req = |(nx.stat & st.irqen);
		nx.ctl.rst_out = 1'b0;
		// No low-power gating here: reset stays armed with the core rail on
		nx.ctl.rst_oe = pins_s.bat_loss ||
			(pins_s.vdd_lt_upper && st.ctrl[`SMC_C_TH1RST] && !st.ctrl[`SMC_C_LOWSEL]) ||
			(pins_s.vdd_lt_lower && st.ctrl[`SMC_C_LOWSEL]);
		nx.ctl.io_prot_en = !lp_mode_i;

		// Overcurrent action chosen by software
		nx.ctl.ovc_timer = ovc_ev && st.ctrl[`SMC_C_LPACT +: 2] == `SMC_LP_TIMER;
		nx.ctl.wd_refresh = ovc_ev && st.ctrl[`SMC_C_LPACT +: 2] == `SMC_LP_WDOG;
		nx.ctl.wake = (ovc_ev && st.ctrl[`SMC_C_LPACT +: 2] == `SMC_LP_WAKE) ||
			(lp_mode_i && st.iocfg[`SMC_IO_CYC] && |io_edge);

		// Pin drivers; the on bits are what low power holds
		for (int i = 0; i < 4; i++) begin
			d = io_drv(st.iocfg[2*i +: 2], st.iocfg[`SMC_IO_LPON + i]);
			if (st.iocfg[`SMC_IO_CYC]) begin
				// Cyclic sense: pin 0 switches, the others only listen
				if (i == 0) begin
					d = (st.iocfg[1:0] == `SMC_IO_IN) ?
						{st.iocfg[`SMC_IO_LPON], 1'b0} : d;
				end else begin
					d = 2'h0;
				end
			end
			nx.ctl.io_hs[i] = d[1];
			nx.ctl.io_ls[i] = d[0];
		end

		// Synchronous reset; battery-loss flag comes up set
		if (!nrst_i) begin
			nx        = '0;
			nx.aw_rdy = 1'b1;
			nx.w_rdy  = 1'b1;
			nx.ar_rdy = 1'b1;
			nx.boot   = 1'b1;
			nx.ctrl   = `SMC_CTRL_RST;
			nx.iocfg  = `SMC_IOCFG_RST;
			nx.stat   = `SMC_STAT_RST;
			nx.irqen  = `SMC_IRQEN_RST;
		end
	end

	always_ff @(posedge core_clk_i) begin
		st <= nx;
	end

	// Bus and control outputs straight from the state
	assign s_axi_awready_o = st.aw_rdy;
	assign s_axi_wready_o  = st.w_rdy;
	assign s_axi_bvalid_o  = st.bvalid;
	assign s_axi_bresp_o   = st.bresp;
	assign s_axi_arready_o = st.ar_rdy;
	assign s_axi_rvalid_o  = st.rvalid;
	assign s_axi_rdata_o   = st.rdata;
	assign s_axi_rresp_o   = st.rresp;
	assign ctl_o           = st.ctl;

	// Checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	property p_loss;
		pins_s.bat_loss |=> st.stat[`SMC_S_LOSS] && st.ctl.por;
	endproperty
	a_loss: assert property (p_loss) else $error("battery loss not flagged");

	property p_ov_irq;
		pins_s.sup_ov && st.irqen[`SMC_S_OV] |=> st.stat[`SMC_S_OV] && st.ctl.int_req;
	endproperty
	a_ov_irq: assert property (p_ov_irq) else $error("overvoltage interrupt missing");

	property p_ovc_wake;
		ovc_ev && st.ctrl[9:8] == `SMC_LP_WAKE |=> st.ctl.wake && !st.ctl.ovc_timer;
	endproperty
	a_ovc_wake: assert property (p_ovc_wake) else $error("overcurrent wake missing");

	property p_boot;
		st.boot |=> ##1 st.ctl.xcvr_en == $past(debug_i, 2);
	endproperty
	a_boot: assert property (p_boot) else $error("rail default wrong");

	property p_mon_gate;
		!st.ctl.xcvr_en |-> st.ctl.mon_sel == `SMC_MON_OFF && !st.ctl.lin_en;
	endproperty
	a_mon_gate: assert property (p_mon_gate) else $error("monitor live, rail off");

	property p_aux_trip;
		st.ctrl[`SMC_C_AUX] && (pins_s.aux_uv || pins_s.aux_oc) |=>
			!st.ctrl[`SMC_C_AUX] && !st.ctl.aux_en;
	endproperty
	a_aux_trip: assert property (p_aux_trip) else $error("aux fault not handled");

	property p_aux_hold;
		!st.ctrl[`SMC_C_AUX] && !(wr_do && st.awaddr == `SMC_ADDR_CTRL) && !st.boot
			|=> !st.ctrl[`SMC_C_AUX];
	endproperty
	a_aux_hold: assert property (p_aux_hold) else $error("aux on without write");

	property p_rst_fail;
		rst_miss [*8] ##0 (st.chk_cnt >= 8'(`SMC_RSTCHK_CYC)) |=> st.stat[`SMC_S_RSTF];
	endproperty
	a_rst_fail: assert property (p_rst_fail) else $error("reset pin fault missed");

	property p_lower;
		st.ctrl[`SMC_C_LOWSEL] && pins_s.vdd_lt_upper && !pins_s.vdd_lt_lower &&
			!pins_s.bat_loss |=> !st.ctl.rst_oe && st.stat[`SMC_S_VWARN];
	endproperty
	a_lower: assert property (p_lower) else $error("upper crossing reset");

	property p_lp_prot;
		lp_mode_i |=> !st.ctl.io_prot_en;
	endproperty
	a_lp_prot: assert property (p_lp_prot) else $error("protection on in low power");

	c_aux_trip: cover property (st.ctrl[`SMC_C_AUX] ##1 !st.ctrl[`SMC_C_AUX]);
	c_mon_sel: cover property (st.ctl.mon_sel != `SMC_MON_OFF);
	c_rst_fail: cover property ($rose(st.stat[`SMC_S_RSTF]));
	c_lp_wake: cover property (st.ctl.wake);
endmodule // smc_top

// ### verification/smc_analog_model.sv
// Behavioural analog section: reset pin with pull-up, transceiver rail settling.
// Assumes ctl_i from smc_top; other detector levels come from the bench.
`timescale 1ns/1ps
module smc_analog_model #(
	parameter int SETTLE = 20
) (
	input  wire logic              core_clk_i,
	input  wire smc_pkg::smc_pins_t drv_i,
	input  wire logic              stuck_low_i,
	input  wire smc_pkg::smc_ctl_t  ctl_i,
	output smc_pkg::smc_pins_t      pins_o
);
	import smc_pkg::*;
	int rail_cnt = 0;
	// Rail charges slowly, so undervoltage lingers after enable
	always @(posedge core_clk_i) begin
		if (!ctl_i.xcvr_en)
			rail_cnt <= 0;
		else if (rail_cnt < SETTLE)
			rail_cnt <= rail_cnt + 1;
	end
	// Pull-up lifts the pin unless driven low or shorted to ground
	always_comb begin
		pins_o = drv_i;
		pins_o.rst_pin_hi = !ctl_i.rst_oe && !stuck_low_i;
		pins_o.xcvr_uv    = (rail_cnt < SETTLE);
	end
endmodule // smc_analog_model

// ### verification/tb_top.sv
// Bench for smc_top: AXI4-Lite register tests plus detector stimulus.
// Assumes smc_analog_model closes the loop on reset pin and rail.
`timescale 1ns/1ps
`include "smc_params.svh"
module tb_top;
	import smc_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        nrst_i     = 1'b0;
	logic        awvalid    = 1'b0;
	logic        wvalid     = 1'b0;
	logic        arvalid    = 1'b0;
	logic [7:0]  awaddr     = 8'h00;
	logic [7:0]  araddr     = 8'h00;
	logic [31:0] wdata      = 32'h0;
	logic        lp_mode    = 1'b0;
	logic        debug      = 1'b0;
	logic        stuck      = 1'b0;
	smc_pins_t   drv        = '0;
	smc_pins_t   pins;
	smc_ctl_t    ctl;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n_w = 0, n_t = 0, n_r = 0, s_w, s_t, s_r;

	// Free-running clock, 10 ns period
	always #5 core_clk_i = ~core_clk_i;

	smc_top u_smc_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
		.s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .lp_mode_i(lp_mode),
		.debug_i(debug), .pins_i(pins), .ctl_o(ctl));

	smc_analog_model u_smc_analog_model (.core_clk_i(core_clk_i), .drv_i(drv),
		.stuck_low_i(stuck), .ctl_i(ctl), .pins_o(pins));

	// Pulse counters, since wake and friends stand for one cycle only
	always @(posedge core_clk_i) begin
		n_w <= n_w + (ctl.wake === 1'b1);
		n_t <= n_t + (ctl.ovc_timer === 1'b1);
		n_r <= n_r + (ctl.wd_refresh === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	// Write: both channels offered together, each dropped once taken
	// No local limit: only the bench timeout ends a wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge core_clk_i);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end while (awvalid || wvalid || bvalid !== 1'b1);
		chk(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge core_clk_i);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge core_clk_i);
		end while (rvalid !== 1'b1);
		chk(rdata, ed);
		chk(rresp, er);
	endtask

	// One threshold case: control word, detector levels, expected reset drive
	task automatic thr(input logic [31:0] c, input smc_pins_t p, input logic lp, input logic e);
		wr(`SMC_ADDR_CTRL, c, `SMC_RESP_OK);
		lp_mode <= lp;
		drv <= p;
		tick(8);
		chk({ctl.rst_out, ctl.rst_oe}, {31'h0, e});
		drv <= '0;
		lp_mode <= 1'b0;
		tick(8);
	endtask

	task automatic do_reset();
		nrst_i <= 1'b0;
		tick(16);
		nrst_i <= 1'b1;
		tick(1);
	endtask

	initial begin
		do_reset();
		tick(10);
		rd(`SMC_ADDR_STAT, 32'h011, `SMC_RESP_OK);
		rd(`SMC_ADDR_CTRL, 32'h0, `SMC_RESP_OK);
		rd(`SMC_ADDR_IOCFG, 32'h0, `SMC_RESP_OK);
		rd(8'h14, 32'h0, `SMC_RESP_ERR);
		wr(8'h14, 32'hffff, `SMC_RESP_ERR);
		wr(`SMC_ADDR_MON, 32'h3, `SMC_RESP_OK);
		tick(2);
		rd(`SMC_ADDR_MON, 32'h0, `SMC_RESP_OK);
		chk({ctl.mon_sel, ctl.lin_en, ctl.xcvr_en, ctl.aux_en}, 32'h0);
		// Rail, aux, pass and load enables together
		wr(`SMC_ADDR_CTRL, 32'h04f, `SMC_RESP_OK);
		tick(2);
		chk({ctl.pass_en, ctl.xcvr_en, ctl.lin_en, ctl.aux_en, ctl.aux_3v3, ctl.mon_load}, 32'h3f);
		wr(`SMC_ADDR_CTRL, 32'h007, `SMC_RESP_OK);
		tick(2);
		chk({ctl.aux_3v3, ctl.mon_load}, 32'h0);
		tick(30); // Settling wait for the rail
		wr(`SMC_ADDR_STAT, 32'h010, `SMC_RESP_OK);
		tick(8);
		rd(`SMC_ADDR_STAT, 32'h001, `SMC_RESP_OK);
		for (int i = 1; i < 8; i++) begin
			wr(`SMC_ADDR_MON, i, `SMC_RESP_OK);
			tick(2);
			chk(ctl.mon_sel, i);
			rd(`SMC_ADDR_MON, i, `SMC_RESP_OK);
		end
		// Aux overcurrent: rail drops and stays off after the fault clears
		wr(`SMC_ADDR_IRQEN, 32'h008, `SMC_RESP_OK);
		drv.aux_oc <= 1'b1;
		tick(8);
		chk({ctl.aux_en, ctl.int_req}, 32'h1);
		rd(`SMC_ADDR_STAT, 32'h009, `SMC_RESP_OK);
		drv.aux_oc <= 1'b0;
		wr(`SMC_ADDR_STAT, 32'h1ff, `SMC_RESP_OK);
		tick(8);
		chk({ctl.aux_en, ctl.int_req}, 32'h0);
		wr(`SMC_ADDR_CTRL, 32'h007, `SMC_RESP_OK);
		tick(2);
		chk(ctl.aux_en, 1'b1);
		// Detector table: pin position against status bit, all unmasked
		wr(`SMC_ADDR_IRQEN, 32'h1ff, `SMC_RESP_OK);
		for (int i = 0; i < 5; i++) begin
			drv <= 15'h1 << ((i == 4) ? 5 : 14 - i);
			tick(8);
			rd(`SMC_ADDR_STAT, 32'h1 << ((i == 4) ? 7 : i), `SMC_RESP_OK);
			chk({ctl.int_req, ctl.por}, (i == 0) ? 32'h3 : 32'h2);
			drv <= '0;
			tick(8);
			wr(`SMC_ADDR_STAT, 32'h1ff, `SMC_RESP_OK);
		end
		wr(`SMC_ADDR_IRQEN, 32'h0, `SMC_RESP_OK);
		thr(32'h002, 15'h0200, 1'b0, 1'b0);
		thr(32'h022, 15'h0200, 1'b0, 1'b0);
		thr(32'h022, 15'h0300, 1'b0, 1'b1);
		thr(32'h022, 15'h0300, 1'b1, 1'b1);
		rd(`SMC_ADDR_STAT, 32'h040, `SMC_RESP_OK);
		thr(32'h012, 15'h0200, 1'b0, 1'b1);
		// I/O modes: pin0 high-side, pin1 low-side, pin2 input, pin3 open
		wr(`SMC_ADDR_IOCFG, 32'hfc9, `SMC_RESP_OK);
		tick(2);
		chk({ctl.io_hs, ctl.io_ls, ctl.io_prot_en}, 32'h025);
		lp_mode <= 1'b1;
		tick(3);
		chk({ctl.io_hs, ctl.io_ls, ctl.io_prot_en}, 32'h024);
		wr(`SMC_ADDR_IOCFG, 32'h0c9, `SMC_RESP_OK);
		tick(2);
		chk({ctl.io_hs, ctl.io_ls}, 32'h0);
		wr(`SMC_ADDR_IOCFG, 32'h1f55, `SMC_RESP_OK);
		tick(2);
		chk({ctl.io_hs, ctl.io_ls}, 32'h10);
		s_w = n_w;
		drv.io_in <= 4'h2;
		tick(8);
		chk(n_w - s_w, 32'h1);
		drv.io_in <= 4'h0;
		wr(`SMC_ADDR_IOCFG, 32'h0, `SMC_RESP_OK);
		// Low-power overcurrent, each action in turn
		for (int a = 0; a < 3; a++) begin
			wr(`SMC_ADDR_CTRL, 32'h002 | (a << 8), `SMC_RESP_OK);
			s_w = n_w;
			s_t = n_t;
			s_r = n_r;
			drv.lp_ovc <= 1'b1;
			tick(8);
			drv.lp_ovc <= 1'b0;
			tick(8);
			chk({8'(n_w - s_w), 8'(n_t - s_t), 8'(n_r - s_r)}, 32'h10000 >> (8 * a));
		end
		lp_mode <= 1'b0;
		// Debug boot turns the rail on by default
		debug <= 1'b1;
		do_reset();
		tick(3);
		chk(ctl.xcvr_en, 1'b1);
		rd(`SMC_ADDR_CTRL, 32'h002, `SMC_RESP_OK);
		tick(30);
		wr(`SMC_ADDR_STAT, 32'h1ff, `SMC_RESP_OK);
		stuck <= 1'b1;
		tick(120);
		rd(`SMC_ADDR_STAT, 32'h020, `SMC_RESP_OK);
		give_verdict();
	end
endmodule // tb_top
